// file: pkg/tpf_cfg.svh
// Behaviour
// - compare mode: A match holds, clears, sets, toggles
// - pwm mode: inactive, active, pwm, single pulse
// - capture: rising, falling, both edges, disabled
// - match to initial level shows no change
// - counter on rise restores initial level
// - before match pin holds initial level
// - pwm: initial-level bit sets active level
// - timer/counter mode ignores level and pin bits
// - single pulse: counter on rise sets level
// - mode field picks compare, capture, pwm, timer
// - source bit picks capture pin or clock pin
// - polarity bit one inverts the output pin except in timer mode
// - complementary pin always inverse of output pin
`ifndef TPF_CFG_SVH
`define TPF_CFG_SVH

// ****************************************
// register map
// ****************************************
`define TPF_OFS_CTRL   4'h0
`define TPF_OFS_RUN    4'h4
`define TPF_OFS_STAT   4'h8
`define TPF_OFS_MASK   4'hc
`define TPF_CTRL_RST   8'h00
`define TPF_RUN_RST    1'b0
`define TPF_STAT_RST   3'h0
`define TPF_MASK_RST   3'h0

// ****************************************
// status bits
// ****************************************
`define TPF_ST_MATCH   0
`define TPF_ST_CAPT    1
`define TPF_ST_PULSE   2

// ****************************************
// pin function codes
// ****************************************
`define TPF_IO_HOLD    2'h0
`define TPF_IO_LOW     2'h1
`define TPF_IO_HIGH    2'h2
`define TPF_IO_TOGGLE  2'h3
`define TPF_IO_INACT   2'h0
`define TPF_IO_ACT     2'h1
`define TPF_IO_PWM     2'h2
`define TPF_IO_PULSE   2'h3
`define TPF_IO_RISE    2'h0
`define TPF_IO_FALL    2'h1
`define TPF_IO_BOTH    2'h2

`endif

// file: pkg/tpf_pkg.sv
// ****************************************
// types
// ****************************************
package tpf_pkg;

  typedef enum logic [1:0] {
    TPF_MODE_CMP = 2'h0,
    TPF_MODE_CAP = 2'h1,
    TPF_MODE_PWM = 2'h2,
    TPF_MODE_TMR = 2'h3
  } tpf_mode_e;

  typedef struct packed {
    tpf_mode_e  mode;
    logic [1:0] pinFunctionSelect;
    logic       outputInitialLevel;
    logic       outputPolarity;
    logic       captureSourceSelect;
    logic       counterClearSelect;
  } tpf_ctrl_s;

  typedef enum logic [1:0] {
    TPF_BUS_IDLE = 2'b01,
    TPF_BUS_ACK  = 2'b10
  } tpf_bus_e;

endpackage : tpf_pkg

// file: rtl/tpf_pin_function.sv
`timescale 1ns/1ps
`include "tpf_cfg.svh"

module tpf_pin_function (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [3:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic              compAMatch,
  input  wire logic              compPMatch,
  input  wire logic              captureInputPin,
  input  wire logic              externalClockPin,
  output logic                   timerOutputPin,
  output logic                   complementaryOutputPin,
  output logic                   captureStrobe,
  output logic                   counterOn,
  output tpf_pkg::tpf_ctrl_s     ctrlOut,
  output logic                   irq
);

  // ****************************************
  // declarations
  // ****************************************
  tpf_pkg::tpf_bus_e  busState_reg;
  tpf_pkg::tpf_bus_e  busState_next;
  logic [7:0]         ctrl_reg;
  logic [7:0]         ctrl_next;
  logic               run_reg;
  logic               run_next;
  logic [2:0]         stat_reg;
  logic [2:0]         stat_next;
  logic [2:0]         mask_reg;
  logic [2:0]         mask_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;
  logic               wait_reg;
  logic               wait_next;
  logic               irq_reg;
  logic               irq_next;
  logic [1:0]         sync1_reg;
  logic [1:0]         sync2_reg;
  logic               srcPrev_reg;
  logic               srcPrev_next;
  logic               onPrev_reg;
  logic               onPrev_next;
  logic               level_reg;
  logic               level_next;
  logic               matched_reg;
  logic               matched_next;
  logic               phase_reg;
  logic               phase_next;
  logic               pulse_reg;
  logic               pulse_next;
  logic               pin_reg;
  logic               pin_next;
  logic               pinB_reg;
  logic               pinB_next;
  logic               capt_reg;
  logic               capt_next;
  tpf_pkg::tpf_ctrl_s ctrl;
  logic               onRise;
  logic               src;
  logic               edgeRise;
  logic               edgeFall;
  logic               evMatch;
  logic               evCapt;
  logic               evPulse;
  logic               busWrite;
  logic               curLevel;

  assign ctrl     = tpf_pkg::tpf_ctrl_s'(ctrl_reg);
  assign onRise   = run_reg & ~onPrev_reg;
  assign busWrite = (busState_reg == tpf_pkg::TPF_BUS_ACK) & write & byteenable[0];

  // ****************************************
  // pin synchronisers
  // ****************************************
  // first stage feeds only the second; edges are judged on stage two
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else begin
      sync1_reg <= {externalClockPin, captureInputPin};
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************
  // capture edge detect
  // ****************************************
  assign src      = ctrl.captureSourceSelect ? sync2_reg[1] : sync2_reg[0];
  assign edgeRise = src & ~srcPrev_reg;
  assign edgeFall = ~src & srcPrev_reg;

  always_comb begin
    srcPrev_next = src;
    capt_next    = 1'b0;
    if (ctrl.mode == tpf_pkg::TPF_MODE_CAP && run_reg) begin
      case (ctrl.pinFunctionSelect)
        `TPF_IO_RISE: begin
          capt_next = edgeRise;
        end
        `TPF_IO_FALL: begin
          capt_next = edgeFall;
        end
        `TPF_IO_BOTH: begin
          capt_next = edgeRise | edgeFall;
        end
        default: begin
          capt_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      srcPrev_reg <= 1'b0;
      capt_reg    <= 1'b0;
    end else begin
      srcPrev_reg <= srcPrev_next;
      capt_reg    <= capt_next;
    end
  end

  // ****************************************
  // output level
  // ****************************************
  // a match is only meaningful while the counter runs
  assign curLevel = matched_reg ? level_reg : ctrl.outputInitialLevel;
  assign evMatch  = (ctrl.mode == tpf_pkg::TPF_MODE_CMP) & run_reg & compAMatch & ~onRise;
  assign evCapt   = capt_next;
  assign evPulse  = (ctrl.mode == tpf_pkg::TPF_MODE_PWM) & (ctrl.pinFunctionSelect == `TPF_IO_PULSE)
                    & run_reg & pulse_reg & compAMatch & ~onRise;

  always_comb begin
    onPrev_next  = run_reg;
    level_next   = level_reg;
    matched_next = matched_reg;
    phase_next   = phase_reg;
    pulse_next   = pulse_reg;
    case (ctrl.mode)
      tpf_pkg::TPF_MODE_CMP: begin
        if (onRise) begin
          matched_next = 1'b0;
          level_next   = ctrl.outputInitialLevel;
        end else if (evMatch) begin
          matched_next = 1'b1;
          case (ctrl.pinFunctionSelect)
            `TPF_IO_HOLD: begin
              level_next = curLevel;
            end
            `TPF_IO_LOW: begin
              level_next = 1'b0;
            end
            `TPF_IO_HIGH: begin
              level_next = 1'b1;
            end
            default: begin
              level_next = ~curLevel;
            end
          endcase
        end else if (!matched_reg) begin
          level_next = ctrl.outputInitialLevel;
        end
      end
      tpf_pkg::TPF_MODE_PWM: begin
        // pin bits are sampled live; changing them while running is unsafe
        if (onRise) begin
          phase_next = 1'b1;
          pulse_next = 1'b1;
        end else if (run_reg && compAMatch) begin
          phase_next = 1'b0;
          pulse_next = 1'b0;
        end else if (run_reg && compPMatch) begin
          phase_next = 1'b1;
        end
        case (ctrl.pinFunctionSelect)
          `TPF_IO_INACT: begin
            level_next = ~ctrl.outputInitialLevel;
          end
          `TPF_IO_ACT: begin
            level_next = ctrl.outputInitialLevel;
          end
          `TPF_IO_PWM: begin
            level_next = phase_next ? ctrl.outputInitialLevel : ~ctrl.outputInitialLevel;
          end
          default: begin
            level_next = pulse_next ? ctrl.outputInitialLevel : ~ctrl.outputInitialLevel;
          end
        endcase
      end
      default: begin
        level_next = 1'b0;
      end
    endcase
    // timer mode leaves the pin low rather than undefined
    if (ctrl.mode == tpf_pkg::TPF_MODE_TMR) begin
      pin_next = 1'b0;
    end else begin
      pin_next = level_next ^ ctrl.outputPolarity;
    end
    pinB_next = ~pin_next;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      onPrev_reg  <= 1'b0;
      level_reg   <= 1'b0;
      matched_reg <= 1'b0;
      phase_reg   <= 1'b0;
      pulse_reg   <= 1'b0;
      pin_reg     <= 1'b0;
      pinB_reg    <= 1'b1;
    end else begin
      onPrev_reg  <= onPrev_next;
      level_reg   <= level_next;
      matched_reg <= matched_next;
      phase_reg   <= phase_next;
      pulse_reg   <= pulse_next;
      pin_reg     <= pin_next;
      pinB_reg    <= pinB_next;
    end
  end

  // ****************************************
  // avalon slave and registers
  // ****************************************
  // one wait cycle: waitrequest drops the cycle after the request is seen
  always_comb begin
    busState_next = busState_reg;
    ctrl_next     = ctrl_reg;
    run_next      = run_reg;
    mask_next     = mask_reg;
    rdata_next    = rdata_reg;
    wait_next     = 1'b1;
    stat_next     = stat_reg;
    case (busState_reg)
      tpf_pkg::TPF_BUS_IDLE: begin
        if (read || write) begin
          busState_next = tpf_pkg::TPF_BUS_ACK;
          wait_next     = 1'b0;
          rdata_next    = 32'h0;
          if (read) begin
            case (address)
              `TPF_OFS_CTRL: begin
                rdata_next = {24'h0, ctrl_reg};
              end
              `TPF_OFS_RUN: begin
                rdata_next = {31'h0, run_reg};
              end
              `TPF_OFS_STAT: begin
                rdata_next = {29'h0, stat_reg};
              end
              `TPF_OFS_MASK: begin
                rdata_next = {29'h0, mask_reg};
              end
              default: begin
                rdata_next = 32'h0;
              end
            endcase
          end
        end
      end
      tpf_pkg::TPF_BUS_ACK: begin
        busState_next = tpf_pkg::TPF_BUS_IDLE;
        if (busWrite) begin
          case (address)
            `TPF_OFS_CTRL: begin
              ctrl_next = writedata[7:0];
            end
            `TPF_OFS_RUN: begin
              run_next = writedata[0];
            end
            `TPF_OFS_STAT: begin
              stat_next = stat_reg & ~writedata[2:0];
            end
            `TPF_OFS_MASK: begin
              mask_next = writedata[2:0];
            end
            default: begin
              run_next = run_reg;
            end
          endcase
        end
      end
      default: begin
        busState_next = tpf_pkg::TPF_BUS_IDLE;
      end
    endcase
    // set beats a same-cycle clear
    stat_next[`TPF_ST_MATCH] = stat_next[`TPF_ST_MATCH] | evMatch;
    stat_next[`TPF_ST_CAPT]  = stat_next[`TPF_ST_CAPT] | evCapt;
    stat_next[`TPF_ST_PULSE] = stat_next[`TPF_ST_PULSE] | evPulse;
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      busState_reg <= tpf_pkg::TPF_BUS_IDLE;
      ctrl_reg     <= `TPF_CTRL_RST;
      run_reg      <= `TPF_RUN_RST;
      stat_reg     <= `TPF_STAT_RST;
      mask_reg     <= `TPF_MASK_RST;
      rdata_reg    <= 32'h0;
      wait_reg     <= 1'b1;
      irq_reg      <= 1'b0;
    end else begin
      busState_reg <= busState_next;
      ctrl_reg     <= ctrl_next;
      run_reg      <= run_next;
      stat_reg     <= stat_next;
      mask_reg     <= mask_next;
      rdata_reg    <= rdata_next;
      wait_reg     <= wait_next;
      irq_reg      <= irq_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign readdata               = rdata_reg;
  assign waitrequest            = wait_reg;
  assign timerOutputPin         = pin_reg;
  assign complementaryOutputPin = pinB_reg;
  assign captureStrobe          = capt_reg;
  assign counterOn              = run_reg;
  assign ctrlOut                = ctrl;
  assign irq                    = irq_reg;

endmodule : tpf_pin_function

// file: test/tpf_pin_function_checker.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module tpf_pin_function_checker (
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic [3:0]         address,
  input wire logic               read,
  input wire logic               write,
  input wire logic [3:0]         byteenable,
  input wire logic [31:0]        writedata,
  input wire logic [31:0]        readdata,
  input wire logic               waitrequest,
  input wire logic               compAMatch,
  input wire logic               compPMatch,
  input wire logic               captureInputPin,
  input wire logic               externalClockPin,
  input wire logic               timerOutputPin,
  input wire logic               complementaryOutputPin,
  input wire logic               captureStrobe,
  input wire logic               counterOn,
  input wire tpf_pkg::tpf_ctrl_s ctrlOut,
  input wire logic               irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire [1:0] md  = ctrlOut.mode;
  wire [1:0] fs  = ctrlOut.pinFunctionSelect;
  wire       oc  = ctrlOut.outputInitialLevel;
  wire       pol = ctrlOut.outputPolarity;
  // a match is only taken once the restart cycle has passed
  sequence cmpHit_s;
    counterOn && $past(counterOn) && md == 2'h0 && compAMatch;
  endsequence
  sequence runRise_s;
    $rose(counterOn) && md == 2'h0;
  endsequence
  pin_inverse_a: assert property (complementaryOutputPin == ~timerOutputPin)
    else $error("complementary pin not inverse");
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer one cycle after request");
  wait_single_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  cmp_toggle_a: assert property (cmpHit_s ##0 fs == 2'h3 |=> timerOutputPin != $past(timerOutputPin))
    else $error("toggle missed");
  cmp_set_a: assert property (cmpHit_s ##0 fs == 2'h2 |=> timerOutputPin == !pol)
    else $error("set missed");
  cmp_clear_a: assert property (cmpHit_s ##0 fs == 2'h1 |=> timerOutputPin == pol)
    else $error("clear missed");
  cmp_hold_a: assert property (cmpHit_s ##0 fs == 2'h0 |=> $stable(timerOutputPin))
    else $error("hold changed pin");
  run_restore_a: assert property (runRise_s |-> ##1 timerOutputPin == (oc ^ pol))
    else $error("restart did not restore level");
  tmr_pin_low_a: assert property (md == 2'h3 && $past(md) == 2'h3 |-> !timerOutputPin)
    else $error("timer mode pin not low");
  capt_mode_a: assert property (captureStrobe |-> md == 2'h1 && fs != 2'h3)
    else $error("capture outside capture mode");
  pwm_force_a: assert property (counterOn && $past(counterOn, 2) && md == 2'h2 && !fs[1]
    |-> timerOutputPin == ((fs[0] ? oc : !oc) ^ pol))
    else $error("forced pwm level wrong");
endmodule : tpf_pin_function_checker
bind tpf_pin_function tpf_pin_function_checker u_tpf_pin_function_checker (.*);

// file: test/tpf_pin_function_tb_top.sv
`timescale 1ns/1ps
// ****
// testbench
// ****
module tpf_pin_function_tb_top;
  logic clock = 0, rstn = 0, read = 0, write = 0, mA = 0, mP = 0, cap = 0, ext = 0;
  logic [3:0] address = 0, be = 4'hf, lag = 0;
  logic [31:0] wd = 0, rd, q;
  logic wr, pin, pinB, stb, on, irq;
  tpf_pkg::tpf_ctrl_s ctl;
  wire ci, ec;
  int fail_count = 0, checks = 0, nStb = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) if (stb === 1'b1) nStb <= nStb + 1;
  tpf_pin_partner u_tpf_pin_partner (.clock(clock), .capLevel(cap), .extLevel(ext), .lag(lag),
    .captureInputPin(ci), .externalClockPin(ec));
  tpf_pin_function u_tpf_pin_function (.clock(clock), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(be), .writedata(wd), .readdata(rd), .waitrequest(wr), .compAMatch(mA),
    .compPMatch(mP), .captureInputPin(ci), .externalClockPin(ec), .timerOutputPin(pin),
    .complementaryOutputPin(pinB), .captureStrobe(stb), .counterOn(on), .ctrlOut(ctl), .irq(irq));
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task pinIs(input logic e);
    chk({30'h0, pinB, pin}, {30'h0, ~e, e});
  endtask : pinIs
  // one Avalon transfer; request held until waitrequest is seen low
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    address <= a; write <= w; read <= !w; wd <= d;
    @(posedge clock);
    while (wr !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20) chk({31'h0, wr}, 32'h0);
    q = rd;
    read <= 0; write <= 0;
    @(posedge clock);
  endtask : bus
  // pin bits only change while stopped, restart reloads the level
  task cfg(input logic [7:0] c);
    bus(4'h4, 1, 0);
    bus(4'h0, 1, {24'h0, c});
    bus(4'h4, 1, 1);
    repeat (3) @(posedge clock);
  endtask : cfg
  task hit(input logic p);
    if (p) mP <= 1;
    else mA <= 1;
    @(posedge clock);
    mA <= 0; mP <= 0;
    repeat (2) @(posedge clock);
  endtask : hit
  task test_regs;
    pinIs(0);
    for (int a = 0; a < 16; a += 4) begin bus(4'(a), 0, 0); chk(q, 0); end
    be <= 0;
    bus(4'h0, 1, 32'hff);
    be <= 4'hf;
    bus(4'h2, 1, 32'hff);
    bus(4'h2, 0, 0); chk(q, 0);
    bus(4'h0, 0, 0); chk(q, 0);
    bus(4'h0, 1, 32'ha5);
    bus(4'h0, 0, 0); chk(q, 32'ha5);
    chk({23'h0, ctl, on}, 32'h0000014a);
  endtask : test_regs
  task test_cmp;
    logic e;
    for (int p = 0; p < 2; p++) for (int o = 0; o < 2; o++) for (int c = 0; c < 4; c++) begin
      cfg({2'h0, 2'(c), 1'(o), 1'(p), 2'h0});
      pinIs(1'(o ^ p));
      e = (c == 0) ? 1'(o) : (c == 1) ? 1'b0 : (c == 2) ? 1'b1 : !1'(o);
      hit(1); pinIs(1'(o ^ p));
      hit(0); pinIs(e ^ 1'(p));
      cfg({2'h0, 2'(c), 1'(o), 1'(p), 2'h0});
      pinIs(1'(o ^ p));
    end
  endtask : test_cmp
  task test_irq;
    bus(4'hc, 1, 1);
    cfg(8'h30);
    bus(4'h8, 1, 7); chk(irq, 0);
    hit(0); chk(irq, 1);
    bus(4'h8, 0, 0); chk(q, 1);
    bus(4'hc, 1, 0); chk(irq, 0);
    bus(4'hc, 1, 1); chk(irq, 1);
    bus(4'h8, 1, 1); bus(4'h8, 0, 0); chk({q[2:0], irq}, 0);
  endtask : test_irq
  task test_pwm;
    for (int o = 0; o < 2; o++) begin
      cfg({2'h2, 2'h0, 1'(o), 3'h0}); pinIs(!1'(o));
      cfg({2'h2, 2'h1, 1'(o), 3'h0}); pinIs(1'(o));
    end
    cfg(8'hac); pinIs(0);
    hit(0); pinIs(1);
    hit(1); pinIs(0);
    cfg(8'hb0); pinIs(0);
    hit(0); pinIs(1);
    hit(1); pinIs(1);
    bus(4'h8, 0, 0); chk(q[2], 1);
  endtask : test_pwm
  task test_tmr;
    cfg(8'hfc); pinIs(0);
    hit(0); pinIs(0);
  endtask : test_tmr
  task flip(input logic s, input logic v);
    if (s) ext <= v;
    else cap <= v;
    repeat (12 + lag) @(posedge clock);
  endtask : flip
  task test_cap;
    int b;
    for (int s = 0; s < 2; s++) for (int c = 0; c < 4; c++) begin
      lag <= 4'(c * 3);
      cfg({2'h1, 2'(c), 2'h0, 1'(s), 1'b0});
      b = nStb;
      flip(!1'(s), 1); flip(!1'(s), 0); chk(nStb - b, 0);
      flip(1'(s), 1); flip(1'(s), 0);
      chk(nStb - b, (c == 2) ? 2 : (c == 3) ? 0 : 1);
    end
  endtask : test_cap
  task summarize;
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1;
    repeat (4) @(posedge clock);
    test_regs;
    test_cmp;
    test_irq;
    test_pwm;
    test_tmr;
    test_cap;
    summarize;
  end
endmodule : tpf_pin_function_tb_top

// file: test/tpf_pin_partner.sv
`timescale 1ns/1ps
// ****
// far-side pin model
// ****
module tpf_pin_partner (
  input  wire logic       clock,
  input  wire logic       capLevel,
  input  wire logic       extLevel,
  input  wire logic [3:0] lag,
  output logic            captureInputPin,
  output logic            externalClockPin
);
  // slow answers: each level passes a delay line lag+1 cycles deep
  logic [15:0] capLine = '0;
  logic [15:0] extLine = '0;
  always @(posedge clock) begin
    capLine <= {capLine[14:0], capLevel};
    extLine <= {extLine[14:0], extLevel};
  end
  assign captureInputPin  = capLine[lag];
  assign externalClockPin = extLine[lag];
endmodule : tpf_pin_partner
